// *** pkg/flash_status_pkg.sv ***
// constants for the serial flash command, status and protection block
// assumes a 50 MHz core clock and a host that frames commands with chip select
package flash_status_pkg;
  localparam int unsigned CLK_MHZ = 50;

  localparam logic [7:0] CMD_LATCH_SET = 8'h06;
  localparam logic [7:0] CMD_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_IDENT = 8'h9F;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERASE_A = 8'h52;
  localparam logic [7:0] CMD_BLOCK_ERASE_B = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] CMD_CHIP_ERASE_B = 8'hC7;

  localparam int BIT_BUSY = 0;
  localparam int BIT_WEL = 1;
  localparam int BIT_PL_LO = 2;
  localparam int BIT_PL_HI = 3;
  localparam int BIT_QE = 6;
  localparam int BIT_SWD = 7;

  localparam logic [1:0] PROTECT_LEVEL_RST = 2'h3;
  localparam logic QUAD_ENABLE_RST = 1'h0;
  localparam logic SWD_RST = 1'h0;
  localparam logic [1:0] PL_NONE = 2'h0;
  localparam logic [1:0] PL_ONE_BLOCK = 2'h1;

  localparam logic [2:0] PHASE_FIRST = 3'h0;
  localparam logic [2:0] PHASE_LAST = 3'h7;
  localparam logic [2:0] BYTES_NONE = 3'h0;
  localparam logic [2:0] BYTES_BARE = 3'h1;
  localparam logic [2:0] BYTES_STATUS_WRITE = 3'h2;
  localparam logic [2:0] BYTES_ADDR = 3'h4;
  localparam logic [2:0] BYTES_PROGRAM_MIN = 3'h5;
  localparam logic [2:0] BYTES_MAX = 3'h7;
  localparam logic [2:0] ID_MAKER = 3'h1;
  localparam logic [2:0] ID_TYPE = 3'h2;
  localparam logic [2:0] ID_DENSITY = 3'h3;

  localparam int unsigned STATUS_WRITE_TIME_US = 10;
  localparam int unsigned PAGE_PROGRAM_TIME_US = 1000;
  localparam int unsigned SECTOR_ERASE_TIME_US = 50000;
  localparam int unsigned BLOCK_ERASE_TIME_US = 500000;
  localparam int unsigned CHIP_ERASE_TIME_US = 2000000;
endpackage : flash_status_pkg

// *** rtl/serial_flash_status_protect.sv ***
// serial flash command front end: latch, identification, status and protection
// assumes host drives cs/sclk/si in mode 0; sclk only toggles while cs is low
`timescale 1ns/1ps
module serial_flash_status_protect #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] MEMORY_TYPE = 8'h3C, // arbitrary value
  parameter logic [7:0] DENSITY_CODE = 8'h11, // arbitrary value
  parameter bit LARGE_PART = 1'b1,
  parameter int unsigned STATUS_WRITE_CYCLES = flash_status_pkg::STATUS_WRITE_TIME_US * flash_status_pkg::CLK_MHZ,
  parameter int unsigned PAGE_PROGRAM_CYCLES = flash_status_pkg::PAGE_PROGRAM_TIME_US * flash_status_pkg::CLK_MHZ,
  parameter int unsigned SECTOR_ERASE_CYCLES = flash_status_pkg::SECTOR_ERASE_TIME_US * flash_status_pkg::CLK_MHZ,
  parameter int unsigned BLOCK_ERASE_CYCLES = flash_status_pkg::BLOCK_ERASE_TIME_US * flash_status_pkg::CLK_MHZ,
  parameter int unsigned CHIP_ERASE_CYCLES = flash_status_pkg::CHIP_ERASE_TIME_US * flash_status_pkg::CLK_MHZ
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  output logic so_out,
  output logic so_oe_out,
  output logic [7:0] status_byte_out,
  output logic quad_mode_out,
  output logic hw_protect_out
);

  // link side: frame state is cleared while chip select is high
  logic link_rst_n;
  assign link_rst_n = rst_n_in & ~cs_n_in;

  logic [2:0] phase, next_phase;
  logic [2:0] nbytes, next_nbytes;
  logic [7:0] cmd, next_cmd;
  logic [7:0] dat, next_dat;

  // msb first, one bit per rising edge
  always_comb begin
    next_phase = phase + 3'h1;
    next_nbytes = nbytes;
    if (phase == flash_status_pkg::PHASE_LAST && nbytes != flash_status_pkg::BYTES_MAX) begin
      next_nbytes = nbytes + 3'h1;
    end
    next_cmd = cmd;
    next_dat = dat;
    if (nbytes == flash_status_pkg::BYTES_NONE) begin
      next_cmd = {cmd[6:0], si_in};
    end else begin
      next_dat = {dat[6:0], si_in};
    end
  end

  always_ff @(posedge sclk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      phase <= flash_status_pkg::PHASE_FIRST;
      nbytes <= flash_status_pkg::BYTES_NONE;
      cmd <= 8'h00;
      dat <= 8'h00;
    end else begin
      phase <= next_phase;
      nbytes <= next_nbytes;
      cmd <= next_cmd;
      dat <= next_dat;
    end
  end

  // frame summary survives chip select rising; core reads it only after
  // the synchronised toggle shows a new command, so the words are stable
  logic [2:0] res_phase, res_nbytes;
  logic [7:0] res_cmd, res_dat;
  logic res_a16, frame_tog;

  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      res_phase <= flash_status_pkg::PHASE_FIRST;
      res_nbytes <= flash_status_pkg::BYTES_NONE;
      res_cmd <= 8'h00;
      res_dat <= 8'h00;
      res_a16 <= 1'b0;
      frame_tog <= 1'b0;
    end else begin
      res_phase <= next_phase;
      res_nbytes <= next_nbytes;
      res_cmd <= next_cmd;
      res_dat <= next_dat;
      if (nbytes == flash_status_pkg::BYTES_BARE && phase == flash_status_pkg::PHASE_LAST) begin
        res_a16 <= si_in;
      end
      if (nbytes == flash_status_pkg::BYTES_NONE && phase == flash_status_pkg::PHASE_LAST) begin
        frame_tog <= ~frame_tog;
      end
    end
  end

  // status snapshot for the link, two stages deep; eight edges pass during the command byte
  logic [7:0] status_byte, st_s1, st_s2;

  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_s1 <= 8'h00;
      st_s2 <= 8'h00;
    end else begin
      st_s1 <= status_byte;
      st_s2 <= st_s1;
    end
  end

  logic [7:0] tx_byte;
  logic tx_on;

  always_comb begin
    tx_byte = 8'h00;
    tx_on = 1'b0;
    if (nbytes != flash_status_pkg::BYTES_NONE) begin
      if (cmd == flash_status_pkg::CMD_STATUS_READ) begin
        tx_on = 1'b1;
        tx_byte = st_s2;
      end else if (cmd == flash_status_pkg::CMD_IDENT && !st_s2[flash_status_pkg::BIT_BUSY]) begin
        tx_on = 1'b1;
        case (nbytes)
          flash_status_pkg::ID_MAKER: tx_byte = MAKER_CODE;
          flash_status_pkg::ID_TYPE: tx_byte = MEMORY_TYPE;
          flash_status_pkg::ID_DENSITY: tx_byte = DENSITY_CODE;
          default: tx_byte = 8'h00;
        endcase
      end
    end
  end

  // driven on the falling edge, msb first
  always_ff @(negedge sclk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_out <= 1'b0;
      so_oe_out <= 1'b0;
    end else begin
      so_out <= tx_byte[flash_status_pkg::PHASE_LAST - phase];
      so_oe_out <= tx_on;
    end
  end

  // core side synchronisers
  logic cs_s1, cs_s2, cs_s3;
  logic tog_s1, tog_s2, tog_seen;
  logic wp_s1, wp_s2;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
    end else begin
      cs_s1 <= cs_n_in;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      tog_s1 <= frame_tog;
      tog_s2 <= tog_s1;
      wp_s1 <= wp_n_in;
      wp_s2 <= wp_s1;
    end
  end

  logic cs_rise, exec;
  assign cs_rise = cs_s2 & ~cs_s3;
  assign exec = cs_rise & (tog_s2 != tog_seen);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tog_seen <= 1'b0;
    end else if (cs_rise) begin
      tog_seen <= tog_s2;
    end
  end

  logic busy, write_enable_latch, qe, status_write_disable;
  logic [1:0] prot_level;
  logic [31:0] timer;

  function automatic logic area_protected(input logic [1:0] level, input logic a16);
    if (level == flash_status_pkg::PL_NONE) begin
      return 1'b0;
    end
    if (level == flash_status_pkg::PL_ONE_BLOCK && LARGE_PART) begin
      return a16;
    end
    return 1'b1;
  endfunction : area_protected

  function automatic logic [31:0] cycle_load(input logic [7:0] code);
    case (code)
      flash_status_pkg::CMD_STATUS_WRITE: return 32'(STATUS_WRITE_CYCLES - 1);
      flash_status_pkg::CMD_PAGE_PROGRAM: return 32'(PAGE_PROGRAM_CYCLES - 1);
      flash_status_pkg::CMD_SECTOR_ERASE: return 32'(SECTOR_ERASE_CYCLES - 1);
      flash_status_pkg::CMD_BLOCK_ERASE_A,
      flash_status_pkg::CMD_BLOCK_ERASE_B: return 32'(BLOCK_ERASE_CYCLES - 1);
      default: return 32'(CHIP_ERASE_CYCLES - 1);
    endcase
  endfunction : cycle_load

  // quad mode takes the pin away from protection
  logic hwp;
  assign hwp = status_write_disable & ~wp_s2 & ~qe;

  logic on_boundary, can_write, do_latch_set_cmd, do_latch_clear_cmd;
  logic do_swr, do_pe, pe_ok, done;

  assign on_boundary = exec & (res_phase == flash_status_pkg::PHASE_FIRST);
  assign can_write = on_boundary & ~busy;
  assign do_latch_set_cmd = can_write & (res_cmd == flash_status_pkg::CMD_LATCH_SET)
                   & (res_nbytes == flash_status_pkg::BYTES_BARE);
  assign do_latch_clear_cmd = can_write & (res_cmd == flash_status_pkg::CMD_LATCH_CLEAR)
                   & (res_nbytes == flash_status_pkg::BYTES_BARE);
  assign do_swr = can_write & write_enable_latch & ~hwp & (res_cmd == flash_status_pkg::CMD_STATUS_WRITE)
                  & (res_nbytes == flash_status_pkg::BYTES_STATUS_WRITE);
  assign do_pe = can_write & write_enable_latch & pe_ok;
  assign done = busy & (timer == 32'h0000_0000);

  // protected area
  always_comb begin
    pe_ok = 1'b0;
    case (res_cmd)
      flash_status_pkg::CMD_PAGE_PROGRAM:
        pe_ok = (res_nbytes >= flash_status_pkg::BYTES_PROGRAM_MIN) & ~area_protected(prot_level, res_a16);
      flash_status_pkg::CMD_SECTOR_ERASE,
      flash_status_pkg::CMD_BLOCK_ERASE_A,
      flash_status_pkg::CMD_BLOCK_ERASE_B:
        pe_ok = (res_nbytes == flash_status_pkg::BYTES_ADDR) & ~area_protected(prot_level, res_a16);
      flash_status_pkg::CMD_CHIP_ERASE_A,
      flash_status_pkg::CMD_CHIP_ERASE_B:
        pe_ok = (res_nbytes == flash_status_pkg::BYTES_BARE) & (prot_level == flash_status_pkg::PL_NONE);
      default: pe_ok = 1'b0;
    endcase
  end

  // self-timed cycle; writes that arrive while busy are dropped, so the host polls busy
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy <= 1'b0;
      timer <= 32'h0000_0000;
    end else if (do_swr || do_pe) begin
      busy <= 1'b1;
      timer <= cycle_load(res_cmd);
    end else if (done) begin
      busy <= 1'b0;
    end else if (busy) begin
      timer <= timer - 32'h0000_0001;
    end
  end

  // set and clear never meet: set needs idle, completion needs busy
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      write_enable_latch <= 1'b0;
    end else if (done || do_latch_clear_cmd) begin
      write_enable_latch <= 1'b0;
    end else if (do_latch_set_cmd) begin
      write_enable_latch <= 1'b1;
    end
  end

  // only the upper fields take the written byte
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prot_level <= flash_status_pkg::PROTECT_LEVEL_RST;
      qe <= flash_status_pkg::QUAD_ENABLE_RST;
      status_write_disable <= flash_status_pkg::SWD_RST;
    end else if (do_swr) begin
      prot_level <= res_dat[flash_status_pkg::BIT_PL_HI:flash_status_pkg::BIT_PL_LO];
      qe <= res_dat[flash_status_pkg::BIT_QE];
      status_write_disable <= res_dat[flash_status_pkg::BIT_SWD];
    end
  end

  // reserved bits read as zero
  always_comb begin
    status_byte = 8'h00;
    status_byte[flash_status_pkg::BIT_BUSY] = busy;
    status_byte[flash_status_pkg::BIT_WEL] = write_enable_latch;
    status_byte[flash_status_pkg::BIT_PL_HI:flash_status_pkg::BIT_PL_LO] = prot_level;
    status_byte[flash_status_pkg::BIT_QE] = qe;
    status_byte[flash_status_pkg::BIT_SWD] = status_write_disable;
  end

  // status and protect outputs come from flops, one core cycle behind the state; quad mode comes straight from qe
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hw_protect_out <= 1'b0;
      status_byte_out <= 8'h0C;
    end else begin
      hw_protect_out <= hwp;
      status_byte_out <= status_byte;
    end
  end
  assign quad_mode_out = qe;

  AST_WEL_SET: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in) do_latch_set_cmd |=> write_enable_latch ##1 write_enable_latch)
    else $error("latch not set by latch-set command");

  AST_WEL_CLEAR: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in) do_latch_clear_cmd |=> !write_enable_latch)
    else $error("latch not cleared by latch-clear command");

  AST_DONE_CLEARS_WEL: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in) $fell(busy) |-> !write_enable_latch && $past(write_enable_latch))
    else $error("latch not consumed by finished cycle");

  AST_BUSY_NEEDS_WEL: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in) $rose(busy) |-> $past(write_enable_latch) && $past(exec))
    else $error("cycle started without latch");

  AST_CHIP_ERASE_GUARD: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    exec && (res_cmd == flash_status_pkg::CMD_CHIP_ERASE_A) && (prot_level != flash_status_pkg::PL_NONE) && !busy
    |=> !busy)
    else $error("chip erase ran while protected");

  AST_HPM_HOLDS: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    exec && hwp && !busy && (res_cmd == flash_status_pkg::CMD_STATUS_WRITE)
    |=> $stable(prot_level) && $stable(status_write_disable) && !busy)
    else $error("status changed under hardware protection");

  AST_SWR_BUSY: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in) do_swr |=> (busy && write_enable_latch) [*8])
    else $error("status write cycle too short");

  AST_SWR_KEEP: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    do_swr |=> status_byte_out[5:4] == 2'h0 && prot_level == $past(res_dat[3:2]))
    else $error("status write touched wrong fields");

  AST_QE_NO_HPM: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in) $past(qe) |-> !hw_protect_out)
    else $error("hardware protection active in quad mode");

  COV_LATCH_SET_CMD: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) do_latch_set_cmd);
  COV_SWR_DONE: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) do_swr ##[1:1000] $fell(busy));
  COV_HPM_REFUSE: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec && hwp && write_enable_latch && (res_cmd == flash_status_pkg::CMD_STATUS_WRITE));
  COV_PROGRAM: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) do_pe);

endmodule : serial_flash_status_protect

// *** verif/spi_host_model.sv ***
// host serial controller model: frames commands on chip select, clock and data in
// assumes mode 0; its clock runs only inside frames at a 32 ns period
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  logic oe_seen;

  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b1;
    oe_seen = 1'b0;
  end

  // bit 39 of tx goes first; rx gathers the output line at each rising edge
  task automatic frame(input int nbits, input logic [39:0] tx, output logic [39:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    cs_n_out = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si_out = tx[39-i];
      #16 sclk_out = 1'b1;
      rx = {rx[38:0], so_in};
      oe_seen = oe_seen | so_oe_in;
      #16 sclk_out = 1'b0;
    end
    #16 cs_n_out = 1'b1;
    // a released line must not keep showing its last bit
    si_out = ~si_out;
    #300;
  endtask : frame
endmodule : spi_host_model

// *** verif/serial_flash_status_protect_tb_top.sv ***
// self-checking bench for the serial flash status and protection block
// assumes the host model in spi_host_model drives the serial side
`timescale 1ns/1ps
module serial_flash_status_protect_tb_top;
  localparam int unsigned CYC = 80;
  localparam logic [23:0] ID = 24'h5A3C11; // arbitrary identity values
  logic core_clk_in = 1'b0;
  logic rst_n_in;
  logic wp_n_in;
  logic sclk, cs_n, si, so, so_oe, quad_mode_out, hw_protect_out;
  logic [7:0] status_byte_out;
  logic [39:0] rx;
  logic [7:0] exp_st;
  logic [7:0] v;
  logic w;
  logic acc;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 32'h09F0D275;
  int cycles = 0;

  always #10 core_clk_in = ~core_clk_in;

  spi_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_in(so_oe));

  serial_flash_status_protect #(
    .MAKER_CODE(ID[23:16]), .MEMORY_TYPE(ID[15:8]), .DENSITY_CODE(ID[7:0]), .LARGE_PART(1'b1),
    .STATUS_WRITE_CYCLES(CYC), .PAGE_PROGRAM_CYCLES(CYC), .SECTOR_ERASE_CYCLES(CYC),
    .BLOCK_ERASE_CYCLES(CYC), .CHIP_ERASE_CYCLES(CYC)
  ) dut (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_n_in(cs_n), .si_in(si),
    .wp_n_in(wp_n_in), .so_out(so), .so_oe_out(so_oe), .status_byte_out(status_byte_out),
    .quad_mode_out(quad_mode_out), .hw_protect_out(hw_protect_out)
  );

  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      give_verdict();
    end
  end

  function automatic logic [7:0] after_write(input logic [7:0] cur, input logic [7:0] val, input logic wp);
    if (cur[7] && !wp && !cur[6]) begin
      return {cur[7:2], 2'b00};
    end
    return {val[7:6], 2'b00, val[3:2], 2'b00};
  endfunction : after_write

  task automatic cmd(input logic [7:0] c);
    host.frame(8, {c, 32'h0}, rx);
  endtask : cmd

  task automatic check_st(input string what, input logic [7:0] e);
    host.frame(24, {8'h05, 32'h0}, rx);
    chk(what, status_byte_out, e);
    chk("status on serial", rx[15:0], {e, e});
  endtask : check_st

  // the host polls busy out by waiting the fixed cycle length before moving on
  task automatic wr(input logic [7:0] val);
    cmd(8'h06);
    host.frame(16, {8'h01, val, 24'h0}, rx);
    #1700;
    cmd(8'h04);
  endtask : wr

  task automatic erase(input int nb, input logic [31:0] c, input logic latch, input logic busy);
    if (latch) begin
      cmd(8'h06);
    end
    host.frame(nb, {c, 8'h00}, rx);
    chk("busy on write", status_byte_out[0], busy);
    if (busy) begin
      host.frame(16, {8'h9F, 32'h0}, rx);
      chk("ident while busy", host.oe_seen, 1'b0);
      chk("busy kept", status_byte_out[0], 1'b1);
    end
    #1700;
    cmd(8'h04);
    check_st("after write cycle", exp_st);
  endtask : erase

  initial begin
    rst_n_in = 1'b0;
    wp_n_in = 1'b1;
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    exp_st = 8'h0C;
    check_st("reset status", exp_st);
    chk("reset outputs", {quad_mode_out, hw_protect_out}, 2'b00);
    host.frame(32, {8'h9F, 32'h0}, rx);
    chk("identity", {host.oe_seen, rx[23:0]}, {1'b1, ID});
    cmd(8'h06);
    chk("latch set", status_byte_out, 8'h0E);
    host.frame(9, {8'h04, 32'h0}, rx);
    chk("ragged clear", status_byte_out, 8'h0E);
    host.frame(15, {8'h01, 8'h00, 24'h0}, rx);
    #1700;
    chk("ragged write", status_byte_out, 8'h0E);
    cmd(8'h04);
    chk("latch clear", status_byte_out, 8'h0C);
    host.frame(16, {8'h01, 8'h00, 24'h0}, rx);
    chk("write without latch", status_byte_out, 8'h0C);
    erase(8, 32'h60000000, 1'b1, 1'b0);
    for (int k = 0; k < 12; k++) begin
      v = (k < 2) ? 8'h80 : 8'($random(seed));
      w = (k == 1) ? 1'b0 : 1'($random(seed));
      @(posedge core_clk_in);
      wp_n_in <= w;
      repeat (6) @(posedge core_clk_in);
      acc = !(exp_st[7] && !w && !exp_st[6]);
      chk("hw protect", hw_protect_out, !acc);
      cmd(8'h06);
      host.frame(16, {8'h01, v, 24'h0}, rx);
      exp_st = after_write(exp_st, v, w);
      chk("busy after write", status_byte_out[1:0], {1'b1, acc});
      host.frame(16, {8'h05, 32'h0}, rx);
      chk("status during write", {rx[7:2], rx[0]}, {exp_st[7:2], acc});
      #1700;
      cmd(8'h04);
      check_st("status after write", exp_st);
      chk("quad mode", quad_mode_out, exp_st[6]);
    end
    @(posedge core_clk_in);
    wp_n_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    chk("pin high leaves", hw_protect_out, 1'b0);
    wr(8'h00);
    exp_st = 8'h00;
    check_st("unprotected", exp_st);
    erase(32, 32'h20000000, 1'b0, 1'b0);
    erase(32, 32'h20000000, 1'b1, 1'b1);
    erase(32, 32'hD8000000, 1'b1, 1'b1);
    erase(40, 32'h02000000, 1'b1, 1'b1);
    erase(8, 32'hC7000000, 1'b1, 1'b1);
    wr(8'h04);
    exp_st = 8'h04;
    erase(32, 32'h52010000, 1'b1, 1'b0);
    erase(32, 32'h20000000, 1'b1, 1'b1);
    erase(8, 32'h60000000, 1'b1, 1'b0);
    give_verdict();
  end
endmodule : serial_flash_status_protect_tb_top
